// >>> design/regulator_thermal_pkg.sv
// constants for the regulator and thermal register bank
package regulator_thermal_pkg;
    // ==========================================
    // register offsets
    localparam logic [7:0] six_ctrl_addr     = 8'h35;
    localparam logic [7:0] four_ctrl_addr    = 8'h36;
    localparam logic [7:0] three_ctrl_addr   = 8'h37;
    localparam logic [7:0] thermal_addr      = 8'h38;
    localparam logic [7:0] irq_status_addr   = 8'h3a;
    localparam logic [7:0] irq_mask_addr     = 8'h3b;
    localparam logic [7:0] tracking_addr     = 8'h3c;
    // ==========================================
    // field layout and reset values
    localparam logic [7:0] narrow_reg_mask   = 8'h7f;
    localparam logic [7:0] thermal_rw_mask   = 8'h0d;
    localparam logic [1:0] hd_sel_reset      = 2'h3;
    localparam logic       ts_enable_reset   = 1'h1;
    localparam logic [7:0] read_zero         = 8'h00;
    // ==========================================
    // supply state codes
    localparam logic [1:0] state_active      = 2'h1;
    localparam logic [1:0] state_sleep       = 2'h3;
    // ==========================================
    // voltage tables in millivolts
    localparam logic [4:0] narrow_floor_code = 5'h03;
    localparam logic [5:0] wide_floor_code   = 6'h04;
    localparam logic [11:0] narrow_base_mv   = 12'h3e8;
    localparam logic [11:0] narrow_step_mv   = 12'h064;
    localparam logic [11:0] wide_base_mv     = 12'h320;
    localparam logic [11:0] wide_step_mv     = 12'h032;
    localparam logic [5:0] wide_top_code     = 6'h32;
    localparam logic [4:0] narrow_top_code   = 5'h19;
endpackage : regulator_thermal_pkg

// >>> design/regulator_thermal_ctrl_regs.sv
// control and status registers for three linear regulators and the thermal monitor
// Overview of operation
// (RULE1) regs three, six: 5-bit code, 1.0 to 3.3 V
// (RULE2) reg four: 6-bit code, 1.0 to 3.3 V
// (RULE3) reg four lowest codes give 0.8-0.9 V
// (RULE4) software keeps reg four code in range
// (RULE5) tracking makes reg four follow core rail
// (RULE6) supply state: 01 active, 11 sleep, else off
// (RULE7) field defaults come from boot configuration
// (RULE8) bit 5 reads hot-die detector
// (RULE9) bit 4 reads shutdown detector
// (RULE10) hot-die threshold select, resets to 3
// (RULE11) bit 0 enables shutdown monitor, resets 1
// (RULE12) bits 5:2 general reset, bit 0 turn-off reset
// (RULE13) reserved and read-only bits ignore writes
// (RULE14) detector inputs synchronised before use
//
// Implementation choice: strobed register access.
`timescale 1ns/100ps
`default_nettype none
module regulator_thermal_ctrl_regs
    import regulator_thermal_pkg::*;
(
    // clock and resets
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic        general_reset_n,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [7:0]  reg_rdata,
    // boot configuration defaults
    input  wire logic        boot_load,
    input  wire logic [7:0]  boot_three,
    input  wire logic [7:0]  boot_four,
    input  wire logic [7:0]  boot_six,
    // thermal detectors and core rail
    input  wire logic        hot_die_raw,
    input  wire logic        shutdown_raw,
    input  wire logic        core_rail_one_active,
    input  wire logic [11:0] core_rail_one_mv,
    // regulator, thermal and interrupt outputs
    output logic      [11:0] linear_regulator_three_mv,
    output logic      [11:0] linear_regulator_four_mv,
    output logic      [11:0] linear_regulator_six_mv,
    output logic      [2:0]  regulator_on,
    output logic      [2:0]  regulator_sleep,
    output logic      [1:0]  hot_die_threshold_select,
    output logic             shutdown_monitor_enable,
    output logic             irq
);
    // ==========================================
    // state
    typedef struct packed {
        logic [7:0] three_r;
        logic [7:0] four_r;
        logic [7:0] six_r;
        logic       track_r;
        logic [1:0] hd_sel_r;
        logic [1:0] hd_sync_r;
        logic [1:0] ts_sync_r;
        logic [1:0] prev_r;
        logic [1:0] irq_stat_r;
        logic [1:0] irq_mask_r;
        logic [7:0] rdata_r;
        logic [11:0] v3_r;
        logic [11:0] v4_r;
        logic [11:0] v6_r;
        logic [2:0] on_r;
        logic [2:0] sleep_r;
        logic       ts_en_r;
    } state_type;

    state_type st_r;
    state_type st_nxt;

    // ==========================================
    // functions
    function automatic logic [11:0] narrow_mv(input logic [4:0] code); // [RULE1]
        logic [4:0] c;
        c = (code < narrow_floor_code) ? 5'h02 : code;
        if (c > narrow_top_code)
            c = narrow_top_code;
        narrow_mv = narrow_base_mv + 12'(c - 5'h02) * narrow_step_mv;
    endfunction : narrow_mv

    function automatic logic [11:0] wide_mv(input logic [5:0] code);
        logic [5:0] c;
        c = (code > wide_top_code) ? wide_top_code : code;
        // codes 0..2 give 0.8..0.9 V, code 3 holds at 1 V [RULE3]
        if (c == 6'h03)
            c = wide_floor_code;
        wide_mv = wide_base_mv + 12'(c) * wide_step_mv; // [RULE2]
    endfunction : wide_mv

    function automatic logic is_on(input logic [1:0] s); // [RULE6]
        is_on = (s == state_active) || (s == state_sleep);
    endfunction : is_on

    // anything outside this list reads as zero
    function automatic logic is_mapped(input logic [7:0] a); // [RULE13]
        is_mapped = (a == six_ctrl_addr) || (a == four_ctrl_addr) || (a == three_ctrl_addr)
                 || (a == thermal_addr) || (a == irq_status_addr) || (a == irq_mask_addr)
                 || (a == tracking_addr);
    endfunction : is_mapped

    // ==========================================
    // next state
    always_comb
    begin
        st_nxt = st_r;
        // first flop feeds only the second [RULE14]
        st_nxt.hd_sync_r = {st_r.hd_sync_r[0], hot_die_raw};
        st_nxt.ts_sync_r = {st_r.ts_sync_r[0], shutdown_raw};
        st_nxt.prev_r    = {st_r.hd_sync_r[1], st_r.ts_sync_r[1]};
        st_nxt.rdata_r   = read_zero;
        if (boot_load)
        begin
            // [RULE7]
            st_nxt.three_r = boot_three & narrow_reg_mask;
            st_nxt.six_r   = boot_six & narrow_reg_mask;
            st_nxt.four_r  = boot_four;
        end
        else if (reg_write)
        begin
            unique case (reg_addr)
                three_ctrl_addr: st_nxt.three_r = reg_wdata & narrow_reg_mask; // [RULE13]
                six_ctrl_addr:   st_nxt.six_r = reg_wdata & narrow_reg_mask;
                four_ctrl_addr:  st_nxt.four_r = reg_wdata; // range kept by software [RULE4]
                thermal_addr:    st_nxt.hd_sel_r = reg_wdata[3:2]; // [RULE10]
                irq_mask_addr:   st_nxt.irq_mask_r = reg_wdata[1:0];
                tracking_addr:   st_nxt.track_r = reg_wdata[0];
                default: ;
            endcase
        end
        // turn-off domain bit: boot load and general reset leave it alone
        if (reg_write && reg_addr == thermal_addr)
            st_nxt.ts_en_r = reg_wdata[0]; // [RULE11]
        if (reg_read && is_mapped(reg_addr))
        begin
            unique case (reg_addr)
                three_ctrl_addr: st_nxt.rdata_r = st_r.three_r;
                six_ctrl_addr:   st_nxt.rdata_r = st_r.six_r;
                four_ctrl_addr:  st_nxt.rdata_r = st_r.four_r;
                thermal_addr:    st_nxt.rdata_r = {2'h0, st_r.hd_sync_r[1], st_r.ts_sync_r[1],
                                                   st_r.hd_sel_r, 1'h0, st_r.ts_en_r}; // [RULE8] [RULE9]
                irq_status_addr: st_nxt.rdata_r = {6'h00, st_r.irq_stat_r};
                irq_mask_addr:   st_nxt.rdata_r = {6'h00, st_r.irq_mask_r};
                tracking_addr:   st_nxt.rdata_r = {7'h00, st_r.track_r};
                default:         st_nxt.rdata_r = read_zero;
            endcase
        end
        // rising detector edges are events; set wins over read clear
        if (reg_read && reg_addr == irq_status_addr)
            st_nxt.irq_stat_r = 2'h0;
        st_nxt.irq_stat_r = st_nxt.irq_stat_r
                          | ({st_r.hd_sync_r[1], st_r.ts_sync_r[1]} & ~st_r.prev_r);
        st_nxt.v3_r = narrow_mv(st_r.three_r[6:2]);
        st_nxt.v6_r = narrow_mv(st_r.six_r[6:2]);
        // [RULE5]
        if (st_r.track_r && core_rail_one_active)
            st_nxt.v4_r = core_rail_one_mv;
        else
            st_nxt.v4_r = wide_mv(st_r.four_r[7:2]);
        st_nxt.on_r    = {is_on(st_r.six_r[1:0]), is_on(st_r.four_r[1:0]),
                          is_on(st_r.three_r[1:0])};
        st_nxt.sleep_r = {st_r.six_r[1:0] == state_sleep, st_r.four_r[1:0] == state_sleep,
                          st_r.three_r[1:0] == state_sleep};
    end

    // ==========================================
    // registers: general reset sets threshold select to 3 and clears the detector synchronisers [RULE12]
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st_r          <= '0;
            st_r.hd_sel_r <= hd_sel_reset;
            st_r.ts_en_r  <= ts_enable_reset; // [RULE11]
        end
        else if (!general_reset_n)
        begin
            st_r           <= st_nxt;
            st_r.hd_sel_r  <= hd_sel_reset;
            st_r.hd_sync_r <= 2'h0;
            st_r.ts_sync_r <= 2'h0;
        end
        else
            st_r <= st_nxt;
    end

    // ==========================================
    // outputs
    assign reg_rdata                 = st_r.rdata_r;
    assign linear_regulator_three_mv = st_r.v3_r;
    assign linear_regulator_four_mv  = st_r.v4_r;
    assign linear_regulator_six_mv   = st_r.v6_r;
    assign regulator_on              = st_r.on_r;
    assign regulator_sleep           = st_r.sleep_r;
    assign hot_die_threshold_select  = st_r.hd_sel_r;
    assign shutdown_monitor_enable   = st_r.ts_en_r;
    assign irq                       = |(st_r.irq_stat_r & st_r.irq_mask_r);

    // ==========================================
    // assertions
    a_reserved_bit_zero: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE13]
        st_r.three_r[7] == 1'b0 && st_r.six_r[7] == 1'b0)
        else $error("reserved bit set");
    a_enable_write: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE11]
        reg_write && reg_addr == thermal_addr |=> shutdown_monitor_enable == $past(reg_wdata[0]))
        else $error("shutdown enable not written");
    a_hd_sel_write: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE10]
        reg_write && !boot_load && general_reset_n && reg_addr == thermal_addr
        |=> hot_die_threshold_select == $past(reg_wdata[3:2]))
        else $error("threshold select not written");
    a_hot_die_read: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE8]
        reg_read && reg_addr == thermal_addr |=> reg_rdata[5] == $past(st_r.hd_sync_r[1]))
        else $error("hot die bit wrong");
    a_shutdown_read: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE9]
        reg_read && reg_addr == thermal_addr |=> reg_rdata[4] == $past(st_r.ts_sync_r[1]))
        else $error("shutdown bit wrong");
    a_sync_delay: assert property (@(posedge sys_clk) disable iff (!reset_n || !general_reset_n) // [RULE14]
        $rose(st_r.hd_sync_r[1]) |-> $past(hot_die_raw, 2))
        else $error("hot die not two-flop synchronised");
    a_state_decode: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE6]
        st_r.three_r[1:0] == 2'h2 && $stable(st_r.three_r) |=> !regulator_on[0])
        else $error("code 10 not off");
    a_track_follow: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE5]
        st_r.track_r && core_rail_one_active |=> linear_regulator_four_mv == $past(core_rail_one_mv))
        else $error("tracking not followed");
    a_four_floor: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE2]
        !st_r.track_r && st_r.four_r[7:2] == 6'h04 |=> linear_regulator_four_mv == 12'h3e8)
        else $error("reg four code 4 not 1 V");
    a_narrow_top: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE1]
        st_r.three_r[6:2] == 5'h19 |=> linear_regulator_three_mv == 12'hce4)
        else $error("reg three top code not 3.3 V");

    // ==========================================
    // assertions: voltage codes and supply states
    a_six_top: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE1]
        st_r.six_r[6:2] == narrow_top_code
        |=> linear_regulator_six_mv == 12'hce4)
        else $error("reg six top code not 3.3 V");
    a_narrow_floor: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE1]
        st_r.three_r[6:2] < narrow_floor_code
        |=> linear_regulator_three_mv == 12'h3e8)
        else $error("reg three low codes not 1 V");
    a_narrow_step: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE1]
        st_r.three_r[6:2] == 5'h03
        |=> linear_regulator_three_mv == 12'h44c)
        else $error("reg three code 3 not 1.1 V");
    a_four_low: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE3]
        !st_r.track_r && st_r.four_r[7:2] == 6'h00
        |=> linear_regulator_four_mv == 12'h320)
        else $error("reg four code 0 not 0.8 V");
    a_four_code_one: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE3]
        !st_r.track_r && st_r.four_r[7:2] == 6'h01
        |=> linear_regulator_four_mv == 12'h352)
        else $error("reg four code 1 not 0.85 V");
    a_four_code_two: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE3]
        !st_r.track_r && st_r.four_r[7:2] == 6'h02
        |=> linear_regulator_four_mv == 12'h384)
        else $error("reg four code 2 not 0.9 V");
    a_four_gap: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE2]
        !st_r.track_r && st_r.four_r[7:2] == 6'h03
        |=> linear_regulator_four_mv == 12'h3e8)
        else $error("reg four code 3 not 1 V");
    a_four_step: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE2]
        !st_r.track_r && st_r.four_r[7:2] == 6'h05
        |=> linear_regulator_four_mv == 12'h41a)
        else $error("reg four code 5 not 1.05 V");
    a_four_top: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE2]
        !st_r.track_r && st_r.four_r[7:2] == wide_top_code
        |=> linear_regulator_four_mv == 12'hce4)
        else $error("reg four top code not 3.3 V");
    a_active_decode: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE6]
        st_r.three_r[1:0] == state_active
        |=> regulator_on[0] && !regulator_sleep[0])
        else $error("code 01 not active");
    a_three_sleep: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE6]
        st_r.three_r[1:0] == state_sleep
        |=> regulator_on[0] && regulator_sleep[0])
        else $error("reg three code 11 not sleep");
    a_sleep_decode: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE6]
        st_r.four_r[1:0] == state_sleep
        |=> regulator_on[1] && regulator_sleep[1])
        else $error("reg four code 11 not sleep");
    a_off_decode: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE6]
        st_r.six_r[1:0] == 2'h0
        |=> !regulator_on[2] && !regulator_sleep[2])
        else $error("code 00 not off");

    // ==========================================
    // assertions: boot load, resets and shutdown synchroniser
    a_boot_four: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE7]
        boot_load
        |=> st_r.four_r == $past(boot_four))
        else $error("boot value not loaded");
    a_boot_mask: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE7]
        boot_load
        |=> st_r.six_r == ($past(boot_six) & narrow_reg_mask))
        else $error("boot value not masked");
    a_general_sel: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE12]
        !general_reset_n
        |=> hot_die_threshold_select == hd_sel_reset)
        else $error("general reset missed threshold select");
    a_general_keep: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE12]
        !general_reset_n && !reg_write
        |=> $stable(shutdown_monitor_enable))
        else $error("general reset touched monitor enable");
    a_ts_sync: assert property (@(posedge sys_clk) disable iff (!reset_n || !general_reset_n) // [RULE14]
        $rose(st_r.ts_sync_r[1])
        |-> $past(shutdown_raw, 2))
        else $error("shutdown not two-flop synchronised");

    // ==========================================
    // assertions: read path and events
    a_unmapped_zero: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE13]
        reg_read && !is_mapped(reg_addr)
        |=> reg_rdata == read_zero)
        else $error("unmapped read not zero");
    a_rdata_idle: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE13]
        !reg_read
        |=> reg_rdata == read_zero)
        else $error("read data not zero when idle");
    a_thermal_reserved: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE13]
        reg_read && reg_addr == thermal_addr
        |=> reg_rdata[7:6] == 2'h0 && reg_rdata[1] == 1'b0)
        else $error("thermal reserved bits not zero");
    a_thermal_sel_read: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE10]
        reg_read && reg_addr == thermal_addr
        |=> reg_rdata[3:2] == $past(hot_die_threshold_select))
        else $error("threshold select read wrong");
    a_enable_read: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE11]
        reg_read && reg_addr == thermal_addr
        |=> reg_rdata[0] == $past(shutdown_monitor_enable))
        else $error("monitor enable read wrong");
    a_hd_event: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE8]
        st_r.hd_sync_r[1] && !st_r.prev_r[1]
        |=> st_r.irq_stat_r[1])
        else $error("hot die rise not latched");
    a_ts_event: assert property (@(posedge sys_clk) disable iff (!reset_n) // [RULE9]
        st_r.ts_sync_r[1] && !st_r.prev_r[0]
        |=> st_r.irq_stat_r[0])
        else $error("shutdown rise not latched");
endmodule : regulator_thermal_ctrl_regs
`default_nettype wire

// >>> verification/tb_regulator_thermal_ctrl_regs.sv
// self-checking bench for the regulator and thermal register bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_total++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb_regulator_thermal_ctrl_regs;
    import regulator_thermal_pkg::*;
    // ==========================================
    // stimulus and observed signals
    logic sys_clk = 0, reset_n = 0, gen_rst_n = 1, wr_s = 0, rd_s = 0, boot_load = 0;
    logic [7:0] addr = 0, wdata = 0, rdata, b3 = 0, b4 = 0, b6 = 0;
    logic hd_raw = 0, ts_raw = 0, core_act = 0, mon_en, irq;
    logic [11:0] core_mv = 0, mv3, mv4, mv6;
    logic [2:0] on, sl;
    logic [1:0] hd_sel;
    int err_total = 0, num_checks = 0;
    regulator_thermal_ctrl_regs uut (.sys_clk(sys_clk), .reset_n(reset_n),
        .general_reset_n(gen_rst_n), .reg_addr(addr), .reg_wdata(wdata), .reg_write(wr_s),
        .reg_read(rd_s), .reg_rdata(rdata), .boot_load(boot_load), .boot_three(b3),
        .boot_four(b4), .boot_six(b6), .hot_die_raw(hd_raw), .shutdown_raw(ts_raw),
        .core_rail_one_active(core_act), .core_rail_one_mv(core_mv),
        .linear_regulator_three_mv(mv3), .linear_regulator_four_mv(mv4),
        .linear_regulator_six_mv(mv6), .regulator_on(on), .regulator_sleep(sl),
        .hot_die_threshold_select(hd_sel), .shutdown_monitor_enable(mon_en), .irq(irq));
    initial forever #12.5 sys_clk = ~sys_clk;
    // ==========================================
    // bus tasks
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk) begin addr <= a; wdata <= d; wr_s <= 1'b1; end
        @(posedge sys_clk) wr_s <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk) begin addr <= a; rd_s <= 1'b1; end
        @(posedge sys_clk) rd_s <= 1'b0;
        #1 `CHK("rdata", e, rdata)
    endtask : rd
    // one cycle for the register, one for the millivolt output
    task automatic setreg(input logic [7:0] a, input logic [7:0] d, input int i,
                          input logic [11:0] mv, input logic o, input logic s);
        logic [11:0] got;
        wr(a, d);
        @(posedge sys_clk) #1;
        got = (i == 0) ? mv3 : (i == 1) ? mv4 : mv6;
        `CHK("mv", mv, got)
        `CHK("on", o, on[i])
        `CHK("sleep", s, sl[i])
    endtask : setreg
    // ==========================================
    // scenarios
    task automatic t_reset;
        rd(thermal_addr, 8'h0d);
        `CHK("hd_sel", 2'h3, hd_sel)
        `CHK("mon_en", 1'b1, mon_en)
        rd(irq_status_addr, 8'h00);
        rd(8'h50, 8'h00);
    endtask : t_reset
    task automatic t_codes;
        setreg(three_ctrl_addr, 8'hff, 0, 12'hce4, 1'b1, 1'b1);
        rd(three_ctrl_addr, 8'h7f);
        setreg(three_ctrl_addr, 8'h0d, 0, 12'h44c, 1'b1, 1'b0);
        setreg(three_ctrl_addr, 8'h65, 0, 12'hce4, 1'b1, 1'b0);
        setreg(three_ctrl_addr, 8'h0e, 0, 12'h44c, 1'b0, 1'b0);
        setreg(six_ctrl_addr, 8'h66, 2, 12'hce4, 1'b0, 1'b0);
        setreg(six_ctrl_addr, 8'h08, 2, 12'h3e8, 1'b0, 1'b0);
        setreg(four_ctrl_addr, 8'h01, 1, 12'h320, 1'b1, 1'b0);
        setreg(four_ctrl_addr, 8'h0b, 1, 12'h384, 1'b1, 1'b1);
        setreg(four_ctrl_addr, 8'h05, 1, 12'h352, 1'b1, 1'b0);
        setreg(four_ctrl_addr, 8'h0c, 1, 12'h3e8, 1'b0, 1'b0);
        setreg(four_ctrl_addr, 8'h10, 1, 12'h3e8, 1'b0, 1'b0);
        setreg(four_ctrl_addr, 8'h14, 1, 12'h41a, 1'b0, 1'b0);
        setreg(four_ctrl_addr, 8'hca, 1, 12'hce4, 1'b0, 1'b0);
        rd(four_ctrl_addr, 8'hca);
    endtask : t_codes
    task automatic t_track;
        wr(tracking_addr, 8'h01);
        core_act <= 1'b1;
        core_mv <= 12'h4b0;
        repeat (3) @(posedge sys_clk);
        #1 `CHK("track", 12'h4b0, mv4)
        core_act <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1 `CHK("untrack", 12'hce4, mv4)
        wr(tracking_addr, 8'h00);
    endtask : t_track
    task automatic t_thermal;
        wr(irq_mask_addr, 8'h02);
        hd_raw <= 1'b1;
        repeat (6) @(posedge sys_clk);
        rd(thermal_addr, 8'h2d);
        `CHK("irq_on", 1'b1, irq)
        rd(irq_status_addr, 8'h02);
        #1 `CHK("irq_clr", 1'b0, irq)
        ts_raw <= 1'b1;
        repeat (6) @(posedge sys_clk);
        rd(thermal_addr, 8'h3d);
        `CHK("irq_mask", 1'b0, irq)
        rd(irq_status_addr, 8'h01);
        wr(thermal_addr, 8'hf2);
        rd(thermal_addr, 8'h30);
        `CHK("mon_en_off", 1'b0, mon_en)
        {hd_raw, ts_raw} <= 2'b00;
        repeat (6) @(posedge sys_clk);
        gen_rst_n <= 1'b0;
        @(posedge sys_clk) gen_rst_n <= 1'b1;
        rd(thermal_addr, 8'h0c);
    endtask : t_thermal
    // turn-off reset in mid-run brings the monitor enable back
    task automatic t_turnoff;
        @(posedge sys_clk) reset_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'b1;
        rd(thermal_addr, 8'h0d);
        `CHK("mon_en_rst", 1'b1, mon_en)
        rd(four_ctrl_addr, 8'h00);
    endtask : t_turnoff
    task automatic t_boot;
        {b3, b4, b6} <= {8'hff, 8'h09, 8'h05};
        boot_load <= 1'b1;
        @(posedge sys_clk) boot_load <= 1'b0;
        rd(three_ctrl_addr, 8'h7f);
        rd(four_ctrl_addr, 8'h09);
        rd(six_ctrl_addr, 8'h05);
    endtask : t_boot
    // ==========================================
    // sequence, watchdog and verdict
    task automatic conclude;
        if (err_total == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : conclude
    initial
    begin
        repeat (10) @(posedge sys_clk);
        reset_n <= 1'b1;
        t_reset();
        t_codes();
        t_track();
        t_thermal();
        t_turnoff();
        t_boot();
        conclude();
    end
    // whole run is about 120 cycles
    initial
    begin
        repeat (5000) @(posedge sys_clk);
        err_total++;
        conclude();
    end
endmodule : tb_regulator_thermal_ctrl_regs
`default_nettype wire
